// ### shared/prot_timer_pkg.sv
package prot_timer_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W         = $clog2(TICK_CYCLES);
  localparam int TMR_W         = 17;

  // ==========================================================
  // selectable times per code, in their own units
  localparam int OCD_US [8]  = '{0, 500, 1000, 2000, 4000, 6100, 8000, 10000};
  localparam int REG_US [8]  = '{0, 1000, 5000, 10000, 50000, 100000, 1000000, 1000000};
  localparam int SOCD_US [8] = '{0, 10, 100, 1000, 10000, 100000, 1000000, 1000000};
  localparam int SOCA_NS [4] = '{0, 200, 500, 1000};
  localparam int BOOST_W_US [2]     = '{100, 1000};
  localparam int BOOST_DUTY_PCT [8] = '{2, 5, 10, 15, 20, 30, 40, 50};
  localparam int RMS_LOG2_BASE = 4;
  localparam int RMS_LOG2_STEP = 3;

  // ==========================================================
  // register map and field layout
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_LIVE   = 8'h0C;
  localparam logic [7:0] OFF_RMS    = 8'h10;
  localparam int CFG_OCD_LSB  = 0;
  localparam int CFG_REG_LSB  = 4;
  localparam int CFG_RMS_LSB  = 8;
  localparam int CFG_SOCD_LSB = 12;
  localparam int CFG_SOCA_LSB = 16;
  localparam int CFG_BW_BIT   = 20;
  localparam int CFG_BD_LSB   = 24;
  localparam int CFG_BEN_BIT  = 28;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam int ST_OCA = 0;
  localparam int ST_REG = 1;
  localparam int ST_SOC = 2;
  localparam int ST_RMS = 3;
  localparam int EV_N   = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // conversions; least times round up, off time rounds down
  function automatic logic [TMR_W-1:0] us_ticks(input int us);
    return TMR_W'((us * 1000 + TICK_NS - 1) / TICK_NS);
  endfunction

  function automatic logic [7:0] ns_cycles(input int ns);
    return 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [TMR_W-1:0] off_ticks(input int w_us, input int pct);
    return TMR_W'(((w_us * (100 - pct)) / pct) * 1000 / TICK_NS);
  endfunction

endpackage

// ### rtl/stage_timer.sv
`timescale 1ns/1ps
`default_nettype none

module stage_timer #(
  parameter int W = 17
) (
  input  wire logic         aclk,    // clock
  input  wire logic         aresetn, // sync reset, active low
  input  wire logic         cond,    // raw condition level
  input  wire logic         step,    // count advance
  input  wire logic [W-1:0] limit,   // steps the condition must hold
  output logic              expired  // condition qualified
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // ==========================================================
  // restart on any drop, so glitches never accumulate
  always_comb begin
    st_nxt = st_r;
    if (!cond) begin
      st_nxt.cnt = '0;
      st_nxt.hit = 1'b0;
    end else if (st_r.cnt >= limit) begin
      st_nxt.hit = 1'b1;
    end else if (step) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.hit;

endmodule

`default_nettype wire

// ### rtl/boost_pulser.sv
`timescale 1ns/1ps
`default_nettype none

module boost_pulser #(
  parameter int W = 17
) (
  input  wire logic         aclk,      // clock
  input  wire logic         aresetn,   // sync reset, active low
  input  wire logic         en,        // boost mode active
  input  wire logic         tick,      // time base pulse
  input  wire logic [W-1:0] on_ticks,  // pulse width
  input  wire logic [W-1:0] off_ticks, // gap between pulses
  output logic              pulse      // boost pulse
);

  typedef struct packed {
    logic         run;
    logic         on;
    logic [W-1:0] cnt;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [W-1:0] span;

  // ==========================================================
  // alternate on and off phases, starting with a pulse
  always_comb begin
    st_nxt = st_r;
    span   = st_r.on ? on_ticks : off_ticks;
    if (!en) begin
      st_nxt = '0;
    end else if (!st_r.run) begin
      st_nxt.run = 1'b1;
      st_nxt.on  = 1'b1;
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (st_r.cnt + 1'b1 >= span) begin
        st_nxt.cnt = '0;
        st_nxt.on  = ~st_r.on;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse = st_r.on;

endmodule

`default_nettype wire

// ### rtl/protection_timer_config.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module protection_timer_config #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                aclk,               // clock
  input  wire logic                aresetn,            // sync reset, active low
  input  wire logic [7:0]          s_axi_awaddr,       // write address
  input  wire logic                s_axi_awvalid,      // write address valid
  output logic                     s_axi_awready,      // write address ready
  input  wire logic [31:0]         s_axi_wdata,        // write data
  input  wire logic [3:0]          s_axi_wstrb,        // byte enables
  input  wire logic                s_axi_wvalid,       // write data valid
  output logic                     s_axi_wready,       // write data ready
  output logic [1:0]               s_axi_bresp,        // write response
  output logic                     s_axi_bvalid,       // write response valid
  input  wire logic                s_axi_bready,       // write response ready
  input  wire logic [7:0]          s_axi_araddr,       // read address
  input  wire logic                s_axi_arvalid,      // read address valid
  output logic                     s_axi_arready,      // read address ready
  output logic [31:0]              s_axi_rdata,        // read data
  output logic [1:0]               s_axi_rresp,        // read response
  output logic                     s_axi_rvalid,       // read data valid
  input  wire logic                s_axi_rready,       // read data ready
  input  wire logic                oc_area_cond,       // raw overcurrent or area condition
  input  wire logic                severe_oc_cond,     // raw severe overcurrent comparator
  input  wire logic                sample_valid,       // new current sample
  input  wire logic [SAMPLE_W-1:0] sample,             // current sample magnitude
  output logic                     oc_area_fault,      // qualified overcurrent or area fault
  output logic                     regulation_expired, // regulation time used up
  output logic                     severe_oc_fault,    // qualified severe overcurrent
  output logic                     boost_pulse,        // boost pulse output
  output logic [31:0]              rms_mean_square,    // last window mean square
  output logic                     irq                 // level interrupt
);

  localparam int AW    = prot_timer_pkg::AXI_ADDR_W;
  localparam int TW    = prot_timer_pkg::TMR_W;
  localparam int EVN   = prot_timer_pkg::EV_N;
  localparam int SQ_W  = 2 * SAMPLE_W;
  localparam int ACC_W = SQ_W + 14;
  localparam int PW    = prot_timer_pkg::PRE_W;

  typedef struct packed {
    logic             aw_full;
    logic [AW-1:0]    aw_addr;
    logic             w_full;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [31:0]      cfg;
    logic [31:0]      mask;
    logic [EVN-1:0]   status;
    logic             irq;
    logic [2:0]       prev;
    logic [ACC_W-1:0] acc;
    logic [13:0]      scnt;
    logic [31:0]      rms;
    logic [PW-1:0]    pre;
    logic             tick;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // ==========================================================
  // configuration fields
  logic [2:0] oc_area_deglitch_sel;
  logic [2:0] oc_area_regulation_time_sel;
  logic [1:0] rms_window_sel;
  logic [2:0] severe_oc_digital_deglitch_sel;
  logic [1:0] severe_oc_analog_deglitch_sel;
  logic       boost_pulse_width_sel;
  logic [2:0] boost_duty_sel;
  logic       boost_en;

  assign oc_area_deglitch_sel           = st_r.cfg[prot_timer_pkg::CFG_OCD_LSB +: 3];
  assign oc_area_regulation_time_sel    = st_r.cfg[prot_timer_pkg::CFG_REG_LSB +: 3];
  assign rms_window_sel                 = st_r.cfg[prot_timer_pkg::CFG_RMS_LSB +: 2];
  assign severe_oc_digital_deglitch_sel = st_r.cfg[prot_timer_pkg::CFG_SOCD_LSB +: 3];
  assign severe_oc_analog_deglitch_sel  = st_r.cfg[prot_timer_pkg::CFG_SOCA_LSB +: 2];
  assign boost_pulse_width_sel          = st_r.cfg[prot_timer_pkg::CFG_BW_BIT];
  assign boost_duty_sel                 = st_r.cfg[prot_timer_pkg::CFG_BD_LSB +: 3];
  assign boost_en                       = st_r.cfg[prot_timer_pkg::CFG_BEN_BIT];

  // ==========================================================
  // per-code limit tables, folded to constants
  logic [TW-1:0] ocd_tbl [8];
  logic [TW-1:0] reg_tbl [8];
  logic [TW-1:0] socd_tbl [8];
  logic [TW-1:0] off_lo_tbl [8];
  logic [TW-1:0] off_hi_tbl [8];
  logic [7:0]    soca_tbl [4];

  for (genvar g = 0; g < 8; g++) begin : g_tbl
    assign ocd_tbl[g]    = prot_timer_pkg::us_ticks(prot_timer_pkg::OCD_US[g]);
    assign reg_tbl[g]    = prot_timer_pkg::us_ticks(prot_timer_pkg::REG_US[g]);
    assign socd_tbl[g]   = prot_timer_pkg::us_ticks(prot_timer_pkg::SOCD_US[g]);
    assign off_lo_tbl[g] = prot_timer_pkg::off_ticks(prot_timer_pkg::BOOST_W_US[0],
                                                     prot_timer_pkg::BOOST_DUTY_PCT[g]);
    assign off_hi_tbl[g] = prot_timer_pkg::off_ticks(prot_timer_pkg::BOOST_W_US[1],
                                                     prot_timer_pkg::BOOST_DUTY_PCT[g]);
    if (g < 4) begin : g_soca
      assign soca_tbl[g] = prot_timer_pkg::ns_cycles(prot_timer_pkg::SOCA_NS[g]);
    end
  end

  // ==========================================================
  // timing stages
  logic          soc_analog_ok;
  logic [TW-1:0] soca_limit;
  logic [TW-1:0] width_ticks;
  logic [TW-1:0] gap_ticks;

  assign soca_limit  = {{(TW - 8){1'b0}}, soca_tbl[severe_oc_analog_deglitch_sel]};
  assign width_ticks = prot_timer_pkg::us_ticks(prot_timer_pkg::BOOST_W_US[1]);

  // width select picks both the pulse and its matching gap
  always_comb begin
    if (boost_pulse_width_sel) begin
      gap_ticks = off_hi_tbl[boost_duty_sel];
    end else begin
      gap_ticks = off_lo_tbl[boost_duty_sel];
    end
  end

  stage_timer #(.W(TW)) u_oc_deglitch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (oc_area_cond),
    .step    (st_r.tick),
    .limit   (ocd_tbl[oc_area_deglitch_sel]),
    .expired (oc_area_fault)
  );

  // regulation is timed only once the condition has qualified
  stage_timer #(.W(TW)) u_regulation (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (oc_area_fault),
    .step    (st_r.tick),
    .limit   (reg_tbl[oc_area_regulation_time_sel]),
    .expired (regulation_expired)
  );

  // analog stage counts raw cycles, digital stage counts ticks
  stage_timer #(.W(TW)) u_soc_analog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (severe_oc_cond),
    .step    (1'b1),
    .limit   (soca_limit),
    .expired (soc_analog_ok)
  );

  stage_timer #(.W(TW)) u_soc_digital (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cond    (soc_analog_ok),
    .step    (st_r.tick),
    .limit   (socd_tbl[severe_oc_digital_deglitch_sel]),
    .expired (severe_oc_fault)
  );

  boost_pulser #(.W(TW)) u_boost (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .en        (boost_en),
    .tick      (st_r.tick),
    .on_ticks  (boost_pulse_width_sel ? width_ticks
                : prot_timer_pkg::us_ticks(prot_timer_pkg::BOOST_W_US[0])),
    .off_ticks (gap_ticks),
    .pulse     (boost_pulse)
  );

  // ==========================================================
  // rms integration helpers
  logic [SQ_W-1:0]  sq;
  logic [ACC_W-1:0] acc_sum;
  logic [13:0]      win_last;
  logic [5:0]       win_log2;

  assign sq       = SQ_W'(sample * sample);
  assign acc_sum  = st_r.acc + ACC_W'(sq);
  assign win_log2 = 6'(prot_timer_pkg::RMS_LOG2_BASE
                    + prot_timer_pkg::RMS_LOG2_STEP * int'(rms_window_sel));
  assign win_last = 14'((32'h1 << win_log2) - 32'h1);

  // ==========================================================
  // register helpers
  logic [3:0]  st_ev;
  logic [3:0]  st_clr;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;
  logic        w_cfg;
  logic        w_mask;
  logic        w_known;

  // byte lanes not enabled keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign w_cfg   = st_r.aw_addr[AW-1:2] == prot_timer_pkg::OFF_CFG[AW-1:2];
  assign w_mask  = st_r.aw_addr[AW-1:2] == prot_timer_pkg::OFF_MASK[AW-1:2];
  assign w_known = w_cfg || w_mask
                   || st_r.aw_addr[AW-1:2] == prot_timer_pkg::OFF_STATUS[AW-1:2]
                   || st_r.aw_addr[AW-1:2] == prot_timer_pkg::OFF_LIVE[AW-1:2]
                   || st_r.aw_addr[AW-1:2] == prot_timer_pkg::OFF_RMS[AW-1:2];

  // read decode; unknown words answer zero with an error
  always_comb begin
    rd_val  = 32'h0000_0000;
    rd_resp = prot_timer_pkg::RESP_OKAY;
    st_clr  = 4'h0;
    case (s_axi_araddr[AW-1:2])
      prot_timer_pkg::OFF_CFG[AW-1:2]: begin
        rd_val = st_r.cfg;
      end
      prot_timer_pkg::OFF_STATUS[AW-1:2]: begin
        rd_val = {28'h000_0000, st_r.status};
        st_clr = 4'hF;
      end
      prot_timer_pkg::OFF_MASK[AW-1:2]: begin
        rd_val = st_r.mask;
      end
      prot_timer_pkg::OFF_LIVE[AW-1:2]: begin
        rd_val = {26'h000_0000, boost_pulse, soc_analog_ok, severe_oc_fault,
                  regulation_expired, oc_area_fault, oc_area_cond};
      end
      prot_timer_pkg::OFF_RMS[AW-1:2]: begin
        rd_val = st_r.rms;
      end
      default: begin
        rd_resp = prot_timer_pkg::RESP_SLVERR;
      end
    endcase
  end

  // rising edges of qualified faults, and each full rms window, become events
  always_comb begin
    st_ev = 4'h0;
    st_ev[prot_timer_pkg::ST_OCA] = oc_area_fault & ~st_r.prev[0];
    st_ev[prot_timer_pkg::ST_REG] = regulation_expired & ~st_r.prev[1];
    st_ev[prot_timer_pkg::ST_SOC] = severe_oc_fault & ~st_r.prev[2];
    st_ev[prot_timer_pkg::ST_RMS] = sample_valid && st_r.scnt >= win_last;
  end

  assign s_axi_awready = ~st_r.aw_full;
  assign s_axi_wready  = ~st_r.w_full;
  assign s_axi_arready = ~st_r.rvalid;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // 10 us time base shared by all tick-counted stages
    st_nxt.tick = 1'b0;
    if (st_r.pre == PW'(prot_timer_pkg::TICK_CYCLES - 1)) begin
      st_nxt.pre  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.pre = st_r.pre + 1'b1;
    end

    // write address and data are taken independently
    if (s_axi_awvalid && !st_r.aw_full) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_full) begin
      st_nxt.w_full = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = w_known ? prot_timer_pkg::RESP_OKAY : prot_timer_pkg::RESP_SLVERR;
      if (w_cfg) begin
        st_nxt.cfg = merge(st_r.cfg, st_r.wdata, st_r.wstrb);
      end
      if (w_mask) begin
        st_nxt.mask = merge(st_r.mask, st_r.wdata, st_r.wstrb);
      end
    end

    // read: one outstanding, status cleared by its own read
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_val;
      st_nxt.rresp  = rd_resp;
      st_nxt.status = st_r.status & ~st_clr;
    end
    // an event in the clearing cycle survives
    st_nxt.status = st_nxt.status | st_ev;
    st_nxt.irq    = |(st_nxt.status & st_nxt.mask[EVN-1:0]);
    st_nxt.prev   = {severe_oc_fault, regulation_expired, oc_area_fault};

    // rms window: sum of squares, mean taken by shift
    if (sample_valid) begin
      if (st_r.scnt >= win_last) begin
        st_nxt.acc  = '0;
        st_nxt.scnt = '0;
        st_nxt.rms  = 32'(acc_sum >> win_log2);
      end else begin
        st_nxt.acc  = acc_sum;
        st_nxt.scnt = st_r.scnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.cfg  <= prot_timer_pkg::CFG_RST;
      st_r.mask <= prot_timer_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid    = st_r.bvalid;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_rvalid    = st_r.rvalid;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  assign rms_mean_square = st_r.rms;
  assign irq             = st_r.irq;

endmodule

`default_nettype wire

// ### bench/prot_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module prot_timer_monitor (
  input wire logic        aclk,               // clock
  input wire logic        aresetn,            // sync reset, active low
  input wire logic        s_axi_arready,      // read address ready
  input wire logic        s_axi_rvalid,       // read data valid
  input wire logic        s_axi_rready,       // read data ready
  input wire logic [31:0] s_axi_rdata,        // read data
  input wire logic        s_axi_bvalid,       // write response valid
  input wire logic        s_axi_bready,       // write response ready
  input wire logic [1:0]  s_axi_bresp,        // write response
  input wire logic        oc_area_cond,       // raw oc condition
  input wire logic        severe_oc_cond,     // raw severe condition
  input wire logic        sample_valid,       // sample strobe
  input wire logic        oc_area_fault,      // qualified fault
  input wire logic        regulation_expired, // regulation used up
  input wire logic        severe_oc_fault,    // qualified severe
  input wire logic [31:0] rms_mean_square,    // window result
  input wire logic        boost_pulse         // boost output
);
  // ==========================================================
  // boost on-phase length, saturating
  logic [16:0] on_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !boost_pulse) on_cnt_r <= 17'h0;
    else if (on_cnt_r != 17'h1FFFF) on_cnt_r <= on_cnt_r + 17'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // fault stages, rms result and boost width
  chk_oc_drop_clear: assert property (!oc_area_cond |=> !oc_area_fault)
    else $error("oc fault held");
  chk_oc_rise_cause: assert property ($rose(oc_area_fault) |-> $past(oc_area_cond))
    else $error("oc fault uncaused");
  chk_reg_after_fault: assert property ($rose(regulation_expired) |-> $past(oc_area_fault))
    else $error("reg uncaused");
  chk_rms_on_sample: assert property (!$stable(rms_mean_square) |-> $past(sample_valid))
    else $error("rms moved");
  // two stages in series, so the drop shows two edges later
  chk_sev_drop_clear: assert property (!severe_oc_cond |-> ##2 !severe_oc_fault)
    else $error("severe held");
  chk_sev_rise_cause: assert property ($rose(severe_oc_fault) |-> $past(severe_oc_cond, 2))
    else $error("severe uncaused");
  chk_boost_width: assert property (boost_pulse |-> on_cnt_r <= 17'd50501)
    else $error("boost too long");
  // ==========================================================
  // bus answers hold until taken, and no read address is taken while an answer waits
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken busy");
  cov_oc: cover property ($rose(oc_area_fault));
  cov_boost: cover property ($fell(boost_pulse));
  cov_sev: cover property ($rose(severe_oc_fault));
endmodule
bind protection_timer_config prot_timer_monitor i_mon (.aclk, .aresetn, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .oc_area_cond, .severe_oc_cond,
  .sample_valid, .oc_area_fault, .regulation_expired, .severe_oc_fault, .rms_mean_square, .boost_pulse);
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1; // always ready
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rms_mean_square;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        oc_area_cond = 0, severe_oc_cond = 0, sample_valid = 0;
  logic [11:0] sample = 12'h0;
  logic        oc_area_fault, regulation_expired, severe_oc_fault, boost_pulse, irq;
  logic [31:0] seed = 32'h5644B902;
  logic [33:0] expq[$];
  int          fail_count = 0, compares = 0, cyc = 0;
  always #10 aclk = ~aclk;
  protection_timer_config i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oc_area_cond,
    .severe_oc_cond, .sample_valid, .sample, .oc_area_fault, .regulation_expired, .severe_oc_fault,
    .boost_pulse, .rms_mean_square, .irq);
  // ==========================================================
  // comparison, verdict, hang guard
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      conclude();
    end
  end
  // read answers against the oldest note
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return oc_area_fault;
      1: return regulation_expired;
      2: return severe_oc_fault;
      3: return boost_pulse;
      default: return !boost_pulse;
    endcase
  endfunction
  // ==========================================================
  // valids drop only once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit done;
    done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) done = 1;
    end
    check(34'(s_axi_bresp), 34'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask
  // bounded wait, edges until output high
  task automatic wait_hi(input int w, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pick(w) !== 1'b1 && n < 30000);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] v, sum;
    logic [11:0] s;
    int          n, lo;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(prot_timer_pkg::OFF_CFG, 34'h0);
    rd(8'h20, {prot_timer_pkg::RESP_SLVERR, 32'h0});
    wr(8'h24, 32'hFFFFFFFF, 4'hF, prot_timer_pkg::RESP_SLVERR);
    // every code of every field but the boost enable bit, read back
    for (int i = 0; i < 8; i++) begin
      v = (i << 0) | (i << 4) | ((i & 3) << 8) | (i << 12) | ((i & 3) << 16) | ((i & 1) << 20) | (i << 24);
      wr(prot_timer_pkg::OFF_CFG, v, 4'hF, prot_timer_pkg::RESP_OKAY);
      rd(prot_timer_pkg::OFF_CFG, {2'h0, v});
    end
    wr(prot_timer_pkg::OFF_CFG, 32'h11111112, 4'h1, prot_timer_pkg::RESP_OKAY);
    rd(prot_timer_pkg::OFF_CFG, {2'h0, v & 32'hFFFFFF00 | 32'h12});
    // severe analog codes; glitch refused at the longest
    for (int c = 0; c < 4; c++) begin
      wr(prot_timer_pkg::OFF_CFG, c << prot_timer_pkg::CFG_SOCA_LSB, 4'hF, prot_timer_pkg::RESP_OKAY);
      lo = prot_timer_pkg::SOCA_NS[c] / prot_timer_pkg::CLK_PERIOD_NS;
      if (c == 3) begin
        severe_oc_cond <= 1'b1;
        repeat (lo - 10) @(posedge aclk);
        severe_oc_cond <= 1'b0;
        repeat (3) @(posedge aclk);
        check(34'(severe_oc_fault), 34'h0);
      end
      severe_oc_cond <= 1'b1;
      wait_hi(2, n);
      check(34'(n >= lo && n <= lo + 4), 34'h1);
      severe_oc_cond <= 1'b0;
      repeat (3) @(posedge aclk);
      check(34'(severe_oc_fault), 34'h0);
    end
    // oc and regulation code 0, events, interrupt
    wr(prot_timer_pkg::OFF_CFG, 32'h0, 4'hF, prot_timer_pkg::RESP_OKAY);
    oc_area_cond <= 1'b1;
    wait_hi(0, n);
    check(34'(n <= 3), 34'h1);
    wait_hi(1, n);
    check(34'(n <= 504), 34'h1);
    oc_area_cond <= 1'b0;
    repeat (3) @(posedge aclk);
    check(34'(irq), 34'h0);
    wr(prot_timer_pkg::OFF_MASK, 32'h1, 4'hF, prot_timer_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(34'(irq), 34'h1);
    rd(prot_timer_pkg::OFF_STATUS, 34'h7);
    rd(prot_timer_pkg::OFF_STATUS, 34'h0);
    check(34'(irq), 34'h0);
    // oc code 1: 49 to 50 ticks by phase
    wr(prot_timer_pkg::OFF_CFG, 32'h1, 4'hF, prot_timer_pkg::RESP_OKAY);
    oc_area_cond <= 1'b1;
    wait_hi(0, n);
    check(34'(n >= 24500 && n <= 25503), 34'h1);
    wait_hi(1, n);
    oc_area_cond <= 1'b0;
    // boost 0.1 ms at 50 percent: 10 ticks on, 10 off
    wr(prot_timer_pkg::OFF_CFG, 32'h17000000, 4'hF, prot_timer_pkg::RESP_OKAY);
    wait_hi(3, n);
    check(34'(n <= 3), 34'h1);
    wait_hi(4, n);
    check(34'(n >= 4500 && n <= 5003), 34'h1);
    wait_hi(3, n);
    check(34'(n >= 4500 && n <= 5003), 34'h1);
    wr(prot_timer_pkg::OFF_CFG, 32'h0, 4'hF, prot_timer_pkg::RESP_OKAY);
    // shortest rms window, random samples
    sum = 32'h0;
    for (int k = 0; k < 16; k++) begin
      s = rnd() & 32'hFFF;
      sum += s * s;
      sample <= s;
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
    check(34'(rms_mean_square), 34'(sum >> 4));
    rd(prot_timer_pkg::OFF_RMS, 34'(sum >> 4));
    rd(prot_timer_pkg::OFF_STATUS, 34'hB);
    conclude();
  end
endmodule
`default_nettype wire
